// ==== common/ulc_pkg.sv ====
// UART channel line, FIFO and modem control: shared constants and types.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
package ulc_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0C;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	localparam logic [7:0] ADDR_INT_STAT = 8'h14;
	localparam logic [7:0] ADDR_INT_MASK = 8'h18;

	// ----------------------------------------
	// Control register layout and reset values
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] rsv_31_29;
		logic hw_flow_enable;
		logic [1:0] rsv_27_26;
		logic send_request;
		logic terminal_ready;
		logic [1:0] rx_fifo_trigger_level;
		logic [1:0] tx_fifo_trigger_level;
		logic rx_fifo_clear;
		logic tx_fifo_clear;
		logic rx_fifo_enable;
		logic tx_fifo_enable;
		logic rsv_15;
		logic ir_mode;
		logic [1:0] word_length_sel;
		logic [7:0] rsv_11_4;
		logic [1:0] rx_mode;
		logic [1:0] tx_mode;
	} ulc_ctrl_s;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h13F3_700F;
	localparam int CTRL_TX_CLEAR_BIT = 18;
	localparam int CTRL_RX_CLEAR_BIT = 19;
	localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
	localparam logic [3:0] INT_RST = 4'h0;

	// Service request modes in tx_mode / rx_mode
	localparam logic [1:0] MODE_IRQ = 2'h1;

	// ----------------------------------------
	// Interrupt status bits
	// ----------------------------------------
	localparam int INT_TX_SVC = 0;
	localparam int INT_RX_SVC = 1;
	localparam int INT_RX_OVR = 2;
	localparam int INT_RX_FRM = 3;
	localparam int INT_W = 4;

	// ----------------------------------------
	// FIFO and thresholds
	// ----------------------------------------
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [5:0] FIFO_FULL = 6'h20;
	localparam logic [5:0] TX_EMPTY_TL0 = 6'h1E;
	localparam logic [5:0] TX_EMPTY_TL1 = 6'h18;
	localparam logic [5:0] TX_EMPTY_TL2 = 6'h10;
	localparam logic [5:0] TX_EMPTY_TL3 = 6'h08;
	localparam logic [5:0] RX_VALID_TL0 = 6'h01;
	localparam logic [5:0] RX_VALID_TL1 = 6'h08;
	localparam logic [5:0] RX_VALID_TL2 = 6'h12;
	localparam logic [5:0] RX_VALID_TL3 = 6'h1C;
	localparam logic [5:0] RTS_HOLD_LEVEL = 6'h1E;

	// ----------------------------------------
	// Bit timing in 16x oversampling ticks
	// ----------------------------------------
	localparam logic [3:0] TICK_SAMPLE = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [2:0] WL_BASE_BITS = 3'h4;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_LOAD = 3'b001,
		TX_START = 3'b010,
		TX_DATA = 3'b011,
		TX_STOP = 3'b100
	} ulc_tx_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} ulc_rx_e;

endpackage

// ==== hw/ulc_fifo.sv ====
// 32 x 8 FIFO with registered read data and a synchronous clear.
// Assumes the caller pops only when count is non-zero; data valid one cycle after pop.
`timescale 1ns/10ps
`default_nettype none
module ulc_fifo (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] rd_data,
	output logic [ulc_pkg::CNT_W-1:0] count
);
	logic [7:0] mem [0:ulc_pkg::FIFO_DEPTH-1];
	logic [ulc_pkg::PTR_W-1:0] wptr_reg;
	logic [ulc_pkg::PTR_W-1:0] rptr_reg;
	logic do_push;
	logic do_pop;

	// A push that meets a clear always lands, even on a full store
	assign do_push = push && (clr || (count != ulc_pkg::FIFO_FULL));
	assign do_pop = pop && (count != '0) && !clr;

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[clr ? '0 : wptr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (do_pop) begin
			rd_data <= mem[rptr_reg];
		end
	end

	// Clear empties the store; a push in the same cycle survives it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count <= '0;
		end else if (clr) begin
			rptr_reg <= '0;
			wptr_reg <= do_push ? ulc_pkg::PTR_W'(1) : '0;
			count <= do_push ? ulc_pkg::CNT_W'(1) : '0;
		end else begin
			if (do_push) begin
				wptr_reg <= wptr_reg + ulc_pkg::PTR_W'(1);
			end
			if (do_pop) begin
				rptr_reg <= rptr_reg + ulc_pkg::PTR_W'(1);
			end
			count <= count + ulc_pkg::CNT_W'(do_push) - ulc_pkg::CNT_W'(do_pop);
		end
	end
endmodule
`default_nettype wire

// ==== hw/ulc_uart.sv ====
// UART channel: word length, infra-red coding, FIFOs, triggers and modem control.
// Assumes a classic Wishbone master and pins synchronous to clk_sys.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Word length code selects five to eight bits
// - IR transmit zero is 3/16 bit pulse
// - IR receive detects 3/16 pulse as zero
// - IR mode bit selects IR or normal
// - Transmit FIFO enable uses 32-byte FIFO
// - Receive FIFO enable uses 32-byte FIFO
// - Transmit FIFO clear spares character in shifter
// - Receive FIFO clear spares character being received
// - Transmit trigger sets empty byte threshold
// - Receive trigger sets valid byte threshold
// - Terminal ready pin low while bit set
// - Send request pin follows bit without flow
// - Hardware flow control drives send request itself
module ulc_uart (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_in,
	output logic tx_out,
	input wire logic cts_in_n,
	input wire logic dcd_in_n,
	output logic terminal_ready_out_n,
	output logic send_request_out_n,
	output logic irq,
	output logic tx_dma_req,
	output logic rx_dma_req
);
	ulc_pkg::ulc_ctrl_s ctrl_reg;
	logic [15:0] baud_reg;
	logic [15:0] baud_cnt_reg;
	logic tick;
	logic [ulc_pkg::INT_W-1:0] int_stat_reg;
	logic [ulc_pkg::INT_W-1:0] int_mask_reg;
	logic [ulc_pkg::INT_W-1:0] int_event;
	logic busy_reg;
	logic req;
	logic [31:0] wmask;
	logic wr_ctrl;
	logic [31:0] rd_mux;
	logic tx_clr;
	logic rx_clr;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [7:0] tx_rd_data;
	logic [7:0] rx_rd_data;
	logic [5:0] tx_count;
	logic [5:0] rx_count;
	logic [5:0] tx_thr;
	logic [5:0] rx_thr;
	logic tx_svc;
	logic rx_svc;
	logic [2:0] wl_last;
	ulc_pkg::ulc_tx_e tx_state_reg;
	logic [3:0] tx_cnt_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_level;
	ulc_pkg::ulc_rx_e rx_state_reg;
	logic [3:0] rx_cnt_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_zero_acc_reg;
	logic rx_zero;
	logic rx_samp;
	logic rx_bit_zero;
	logic [7:0] rx_word;
	logic rx_room;
	logic rx_done;
	logic rx_frame_err;

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !busy_reg && !wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_ctrl = req && wb_we_i && (wb_adr_i == ulc_pkg::ADDR_CTRL);
	assign tx_clr = wr_ctrl && wb_sel_i[2] && wb_dat_i[ulc_pkg::CTRL_TX_CLEAR_BIT];
	assign rx_clr = wr_ctrl && wb_sel_i[2] && wb_dat_i[ulc_pkg::CTRL_RX_CLEAR_BIT];
	assign tx_push = req && wb_we_i && (wb_adr_i == ulc_pkg::ADDR_TXDATA) && wb_sel_i[0]
		&& (ctrl_reg.tx_fifo_enable ? (tx_count != ulc_pkg::FIFO_FULL) : (tx_count == '0));
	assign rx_pop = req && !wb_we_i && (wb_adr_i == ulc_pkg::ADDR_RXDATA) && (rx_count != '0);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			wb_ack_o <= 1'b0;
		end else begin
			busy_reg <= req;
			wb_ack_o <= busy_reg;
		end
	end

	always_comb begin
		case (wb_adr_i)
			ulc_pkg::ADDR_CTRL: rd_mux = ctrl_reg;
			ulc_pkg::ADDR_STATUS: rd_mux = {12'h000, rx_svc, tx_svc, rx_state_reg != ulc_pkg::RX_IDLE,
				tx_state_reg != ulc_pkg::TX_IDLE, 2'h0, rx_count, 2'h0, tx_count};
			ulc_pkg::ADDR_RXDATA: rd_mux = {24'h000000, rx_rd_data};
			ulc_pkg::ADDR_BAUD: rd_mux = {16'h0000, baud_reg};
			ulc_pkg::ADDR_INT_STAT: rd_mux = {28'h0000000, int_stat_reg};
			ulc_pkg::ADDR_INT_MASK: rd_mux = {28'h0000000, int_mask_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (busy_reg) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// Reserved and pulse bits not stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= ulc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= (ctrl_reg & ~(wmask & ulc_pkg::CTRL_WMASK)) | (wb_dat_i & wmask & ulc_pkg::CTRL_WMASK);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_reg <= ulc_pkg::BAUD_DIV_RST;
			int_mask_reg <= ulc_pkg::INT_RST;
		end else if (req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == ulc_pkg::ADDR_BAUD) begin
				baud_reg <= {wb_sel_i[1] ? wb_dat_i[15:8] : baud_reg[15:8], wb_dat_i[7:0]};
			end
			if (wb_adr_i == ulc_pkg::ADDR_INT_MASK) begin
				int_mask_reg <= wb_dat_i[ulc_pkg::INT_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupts: sticky, write one to clear, set wins
	// ----------------------------------------
	assign int_event = {rx_frame_err, rx_done && !rx_room && !rx_clr,
		rx_svc && (ctrl_reg.rx_mode == ulc_pkg::MODE_IRQ), tx_svc && (ctrl_reg.tx_mode == ulc_pkg::MODE_IRQ)};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_stat_reg <= ulc_pkg::INT_RST;
		end else if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ulc_pkg::ADDR_INT_STAT)) begin
			int_stat_reg <= (int_stat_reg & ~wb_dat_i[ulc_pkg::INT_W-1:0]) | int_event;
		end else begin
			int_stat_reg <= int_stat_reg | int_event;
		end
	end

	// ----------------------------------------
	// Triggers, service requests, modem pins
	// ----------------------------------------
	// Transmit empty thresholds
	always_comb begin
		case (ctrl_reg.tx_fifo_trigger_level)
			2'h0: tx_thr = ulc_pkg::TX_EMPTY_TL0;
			2'h1: tx_thr = ulc_pkg::TX_EMPTY_TL1;
			2'h2: tx_thr = ulc_pkg::TX_EMPTY_TL2;
			default: tx_thr = ulc_pkg::TX_EMPTY_TL3;
		endcase
	end

	always_comb begin
		case (ctrl_reg.rx_fifo_trigger_level)
			2'h0: rx_thr = ulc_pkg::RX_VALID_TL0;
			2'h1: rx_thr = ulc_pkg::RX_VALID_TL1;
			2'h2: rx_thr = ulc_pkg::RX_VALID_TL2;
			default: rx_thr = ulc_pkg::RX_VALID_TL3;
		endcase
	end

	assign tx_svc = ctrl_reg.tx_fifo_enable ? ((ulc_pkg::FIFO_FULL - tx_count) >= tx_thr) : (tx_count == '0);
	assign rx_svc = ctrl_reg.rx_fifo_enable ? (rx_count >= rx_thr) : (rx_count != '0);

	// Service request by interrupt or DMA
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
		end else begin
			irq <= |(int_stat_reg & int_mask_reg);
			tx_dma_req <= tx_svc && ctrl_reg.tx_mode[1];
			rx_dma_req <= rx_svc && ctrl_reg.rx_mode[1];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			terminal_ready_out_n <= 1'b1;
			send_request_out_n <= 1'b1;
		end else begin
			terminal_ready_out_n <= !ctrl_reg.terminal_ready;
			if (ctrl_reg.hw_flow_enable) begin
				send_request_out_n <= rx_count >= ulc_pkg::RTS_HOLD_LEVEL;
			end else begin
				send_request_out_n <= !ctrl_reg.send_request;
			end
		end
	end

	// ----------------------------------------
	// Baud tick, 16 per bit
	// ----------------------------------------
	assign tick = (baud_cnt_reg == baud_reg);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt_reg <= 16'h0000;
		end else begin
			baud_cnt_reg <= tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
		end
	end

	// Last data bit index from word length
	assign wl_last = ulc_pkg::WL_BASE_BITS + {1'b0, ctrl_reg.word_length_sel};

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	// Clear-to-send gates frame start
	assign tx_pop = (tx_state_reg == ulc_pkg::TX_IDLE) && (tx_count != '0)
		&& (!ctrl_reg.hw_flow_enable || !cts_in_n);

	// Shifter keeps its character through clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= ulc_pkg::TX_IDLE;
			tx_cnt_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
		end else begin
			case (tx_state_reg)
				ulc_pkg::TX_IDLE: begin
					if (tx_pop) begin
						tx_state_reg <= ulc_pkg::TX_LOAD;
					end
				end
				ulc_pkg::TX_LOAD: begin
					tx_shift_reg <= tx_rd_data;
					tx_cnt_reg <= 4'h0;
					tx_bit_reg <= 3'h0;
					tx_state_reg <= ulc_pkg::TX_START;
				end
				ulc_pkg::TX_START, ulc_pkg::TX_DATA, ulc_pkg::TX_STOP: begin
					if (tick) begin
						tx_cnt_reg <= tx_cnt_reg + 4'h1;
						if (tx_cnt_reg == ulc_pkg::TICK_LAST) begin
							if (tx_state_reg == ulc_pkg::TX_START) begin
								tx_state_reg <= ulc_pkg::TX_DATA;
							end else if (tx_state_reg == ulc_pkg::TX_STOP) begin
								tx_state_reg <= ulc_pkg::TX_IDLE;
							end else begin
								tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
								tx_bit_reg <= tx_bit_reg + 3'h1;
								if (tx_bit_reg == wl_last) begin
									tx_state_reg <= ulc_pkg::TX_STOP;
								end
							end
						end
					end
				end
				default: tx_state_reg <= ulc_pkg::TX_IDLE;
			endcase
		end
	end

	assign tx_level = (tx_state_reg == ulc_pkg::TX_START) ? 1'b0
		: (tx_state_reg == ulc_pkg::TX_DATA) ? tx_shift_reg[0] : 1'b1;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
		end else if (ctrl_reg.ir_mode) begin
			// Zero sent as short high pulse
			tx_out <= !tx_level && (tx_cnt_reg < ulc_pkg::IR_PULSE_TICKS);
		end else begin
			tx_out <= tx_level;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	// Zero level depends on mode
	assign rx_zero = ctrl_reg.ir_mode ? rx_in : !rx_in;
	// In IR mode any pulse within the bit marks zero; normal mode samples only at tick 7
	assign rx_samp = ctrl_reg.ir_mode ? rx_zero : ((rx_cnt_reg == ulc_pkg::TICK_SAMPLE) && rx_zero);
	assign rx_bit_zero = rx_zero_acc_reg || rx_samp;
	assign rx_done = tick && (rx_state_reg == ulc_pkg::RX_STOP) && (rx_cnt_reg == ulc_pkg::TICK_LAST) && !rx_bit_zero;
	assign rx_frame_err = tick && (rx_state_reg == ulc_pkg::RX_STOP) && (rx_cnt_reg == ulc_pkg::TICK_LAST) && rx_bit_zero;
	assign rx_room = ctrl_reg.rx_fifo_enable ? (rx_count != ulc_pkg::FIFO_FULL) : (rx_count == '0);
	// Character in flight pushed even across clear
	assign rx_push = rx_done && (rx_room || rx_clr);
	assign rx_word = rx_shift_reg >> (3'h7 - wl_last);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_reg <= ulc_pkg::RX_IDLE;
			rx_cnt_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_zero_acc_reg <= 1'b0;
		end else if (tick) begin
			rx_cnt_reg <= rx_cnt_reg + 4'h1;
			rx_zero_acc_reg <= (rx_cnt_reg == ulc_pkg::TICK_LAST) ? 1'b0 : rx_bit_zero;
			case (rx_state_reg)
				ulc_pkg::RX_IDLE: begin
					rx_cnt_reg <= 4'h1;
					rx_bit_reg <= 3'h0;
					rx_zero_acc_reg <= ctrl_reg.ir_mode;
					if (rx_zero && (!ctrl_reg.hw_flow_enable || !dcd_in_n)) begin
						rx_state_reg <= ulc_pkg::RX_START;
					end
				end
				ulc_pkg::RX_START: begin
					if (rx_cnt_reg == ulc_pkg::TICK_LAST) begin
						rx_state_reg <= rx_bit_zero ? ulc_pkg::RX_DATA : ulc_pkg::RX_IDLE;
					end
				end
				ulc_pkg::RX_DATA: begin
					if (rx_cnt_reg == ulc_pkg::TICK_LAST) begin
						rx_shift_reg <= {!rx_bit_zero, rx_shift_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == wl_last) begin
							rx_state_reg <= ulc_pkg::RX_STOP;
						end
					end
				end
				ulc_pkg::RX_STOP: begin
					if (rx_cnt_reg == ulc_pkg::TICK_LAST) begin
						rx_state_reg <= ulc_pkg::RX_IDLE;
					end
				end
				default: rx_state_reg <= ulc_pkg::RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// FIFOs
	// ----------------------------------------
	ulc_fifo u_tx_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clr(tx_clr),
		.push(tx_push),
		.push_data(wb_dat_i[7:0]),
		.pop(tx_pop),
		.rd_data(tx_rd_data),
		.count(tx_count)
	);

	ulc_fifo u_rx_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clr(rx_clr),
		.push(rx_push),
		.push_data(rx_word),
		.pop(rx_pop),
		.rd_data(rx_rd_data),
		.count(rx_count)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_bus_ack_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req |-> ##2 wb_ack_o ##1 !wb_ack_o) else $error("ack not at second edge");
	a_dtr_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ctrl && wb_sel_i[3] && wb_dat_i[24] |-> ##2 !terminal_ready_out_n) else $error("dtr pin not low");
	a_rts_soft: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!ctrl_reg.hw_flow_enable && ctrl_reg.send_request)[*2] |-> !send_request_out_n) else $error("rts pin high");
	a_rts_hw_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_reg.hw_flow_enable && rx_count >= ulc_pkg::RTS_HOLD_LEVEL |=> send_request_out_n) else $error("rts not held");
	a_ir_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_reg.ir_mode && tx_state_reg == ulc_pkg::TX_START && tx_cnt_reg >= 4'h3 |=> !tx_out) else $error("ir pulse long");
	a_ir_pulse_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_reg.ir_mode && tx_state_reg == ulc_pkg::TX_START && tx_cnt_reg < 4'h3 |=> tx_out) else $error("ir pulse missing");
	a_norm_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl_reg.ir_mode && tx_state_reg == ulc_pkg::TX_START |=> !tx_out) else $error("start bit not low");
	a_wl_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tick && tx_state_reg == ulc_pkg::TX_DATA && tx_cnt_reg == 4'hF && tx_bit_reg == wl_last
		|=> tx_state_reg == ulc_pkg::TX_STOP) else $error("word length wrong");
	a_txclr_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_clr |=> tx_count == 6'h00) else $error("tx fifo not cleared");
	a_rx_trigger: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_reg.rx_fifo_enable && ctrl_reg.rx_mode[1] && rx_count >= rx_thr |=> rx_dma_req) else $error("rx request missing");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		|(int_stat_reg & int_mask_reg) |=> irq) else $error("irq not raised");
endmodule
`default_nettype wire

// ==== tb/ulc_peer.sv ====
// Serial peer model: sends and captures UART frames, normal or IR coded.
// Assumes baud divisor zero, so one bit lasts 16 clk_sys cycles.
`timescale 1ns/10ps
`default_nettype none
module ulc_peer (
	input wire logic clk_sys,
	input wire logic ir,
	input wire logic tx_line,
	output logic rx_line,
	output logic cts_n,
	output logic dcd_n
);
	// Modem side always ready
	assign cts_n = 1'b0;
	assign dcd_n = 1'b0;
	initial rx_line = 1'b1;
	// Idle level: low in IR, high otherwise
	always @(ir) rx_line <= !ir;

	task automatic send(input logic [7:0] d, input int n);
		logic b;
		for (int i = 0; i < n + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
			for (int t = 0; t < 16; t++) begin
				@(posedge clk_sys);
				rx_line <= ir ? (!b && t < 3) : b;
			end
		end
	endtask

	// Capture n data bits, pw is the IR start pulse width, -1 if no start came
	task automatic recv(output logic [7:0] d, input int n, output int pw);
		int k;
		d = 8'h00;
		pw = 0;
		k = 0;
		while (tx_line !== ir && k < 4000) begin
			@(posedge clk_sys);
			k++;
		end
		while (ir && tx_line === 1'b1 && pw < 20) begin
			@(posedge clk_sys);
			pw++;
		end
		repeat (16 + (ir ? 1 : 8) - pw) @(posedge clk_sys);
		for (int j = 0; j < n; j++) begin
			d[j] = tx_line ^ ir;
			repeat (16) @(posedge clk_sys);
		end
		if (k >= 4000) begin
			pw = -1;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/uart_line_fifo_modem_control_tb.sv ====
// Testbench for the UART channel control block.
// Assumes the serial peer model and 50 MHz clk_sys.
`timescale 1ns/10ps
`default_nettype none
module uart_line_fifo_modem_control_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic ack, rx_in, tx_out, cts_n, dcd_n, dtr_n, rts_n, irq;
	logic tx_dma, rx_dma;
	logic ir = 1'b0;
	logic [7:0] d;
	logic [7:0] mk;
	int errors = 0;
	int compares = 0;
	int pw;

	always #10 clk_sys = ~clk_sys;

	ulc_uart ulc_uart_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rx_in(rx_in), .tx_out(tx_out), .cts_in_n(cts_n), .dcd_in_n(dcd_n),
		.terminal_ready_out_n(dtr_n), .send_request_out_n(rts_n), .irq(irq),
		.tx_dma_req(tx_dma), .rx_dma_req(rx_dma));

	ulc_peer ulc_peer_i (.clk_sys(clk_sys), .ir(ir), .tx_line(tx_out), .rx_line(rx_in),
		.cts_n(cts_n), .dcd_n(dcd_n));

	task automatic results();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Classic Wishbone single cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		sel <= 4'hF;
		@(posedge clk_sys);
		while (ack !== 1'b1) begin
			k++;
			if (k > 50) begin
				errors++;
				results();
			end
			@(posedge clk_sys);
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(0, ulc_pkg::ADDR_CTRL, 0);
		chk(rdat, 32'h0);
		chk({dtr_n, rts_n}, 32'h3);
		bus(0, 8'h40, 0);
		chk(rdat, 32'h0);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h0100_0000);
		chk({dtr_n, rts_n}, 32'h1);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h0200_0000);
		chk({dtr_n, rts_n}, 32'h2);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h1100_0000);
		chk({dtr_n, rts_n}, 32'h0);
		$display("test modem done");
		for (int m = 0; m < 8; m++) begin
			ir <= ~m[2];
			mk = 8'hFF >> (3 - m[1:0]);
			bus(1, ulc_pkg::ADDR_CTRL, {17'h0, ~m[2], m[1:0], 12'h000});
			repeat (300) @(posedge clk_sys);
			bus(0, ulc_pkg::ADDR_RXDATA, 0);
			fork
				bus(1, ulc_pkg::ADDR_TXDATA, 32'hA5);
				ulc_peer_i.recv(d, 5 + m[1:0], pw);
			join
			if (pw < 0) begin
				errors++;
				results();
			end
			chk(d, 8'hA5 & mk);
			if (!m[2])
				chk(pw, 3);
			ulc_peer_i.send(8'h5A, 5 + m[1:0]);
			repeat (20) @(posedge clk_sys);
			bus(0, ulc_pkg::ADDR_RXDATA, 0);
			chk(rdat, 8'h5A & mk);
		end
		$display("test word length done");
		bus(1, ulc_pkg::ADDR_INT_MASK, 32'h2);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h1042_3004);
		for (int i = 0; i < 30; i++) begin
			chk(irq, i >= 8);
			chk(rts_n, 0);
			ulc_peer_i.send(8'(i), 8);
			repeat (20) @(posedge clk_sys);
		end
		chk(irq, 1);
		chk(rts_n, 1);
		bus(0, ulc_pkg::ADDR_STATUS, 0);
		chk(rdat[13:8], 30);
		bus(1, ulc_pkg::ADDR_INT_MASK, 0);
		repeat (2) @(posedge clk_sys);
		chk(irq, 0);
		bus(1, ulc_pkg::ADDR_INT_MASK, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h1042_3008);
		chk(rx_dma, 1);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h104A_3004);
		bus(0, ulc_pkg::ADDR_STATUS, 0);
		chk(rdat[13:8], 0);
		chk(rts_n, 0);
		bus(1, ulc_pkg::ADDR_INT_STAT, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk(irq, 0);
		$display("test rx fifo done");
		bus(1, ulc_pkg::ADDR_CTRL, 32'h0001_3000);
		fork
			ulc_peer_i.recv(d, 8, pw);
			begin
				bus(1, ulc_pkg::ADDR_TXDATA, 32'h3C);
				bus(1, ulc_pkg::ADDR_TXDATA, 32'hC3);
				bus(1, ulc_pkg::ADDR_TXDATA, 32'h99);
				bus(0, ulc_pkg::ADDR_STATUS, 0);
				chk(rdat[5:0], 2);
				bus(1, ulc_pkg::ADDR_CTRL, 32'h0005_3000);
				bus(0, ulc_pkg::ADDR_STATUS, 0);
			end
		join
		if (pw < 0) begin
			errors++;
			results();
		end
		chk(rdat[5:0], 0);
		chk(d, 8'h3C);
		bus(1, ulc_pkg::ADDR_CTRL, 32'h0001_3002);
		chk(tx_dma, 1);
		repeat (20) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			bus(1, ulc_pkg::ADDR_TXDATA, i);
			chk(tx_dma, i < 3);
		end
		$display("test tx fifo done");
		results();
	end
endmodule
`default_nettype wire
